// >>> src/rsc_reset_sequencer.sv
// Reset sequence controller with Wishbone register slave
// Behaviour
// - POR, clock/lock loss, stop-mode pin are asynchronous
// - Synchronous request waits bus end, then asserts
// - Bus monitor forced on while deferring
// - Running writes finish; a cycle is cut only by monitor timeout or an async request in bus wait
// - Asynchronous sources assert reset without waiting
// - Power-up holds reset: supply, lock, 512
// - Pin low four edges latches external request
// - Stop-mode pin reset recognised without the four-edge count
// - Clock loss reset: PLL mode, enabled, failure
// - Lock loss reset: PLL mode, enabled, unlock
// - Software bit starts synchronous reset path
// - Synchronous order: latch, monitor, assert, waits, release
// - Pin reasserted in lock/count returns to pin wait
// - Internal asynchronous: assert, lock, count, release
// - Lock lost in count returns to lock wait
// - Power-on restarts sequence from initial state
// - Loss during bus wait ends cycle, latches, waits pin
// - Lock loss during count restarts the count from zero after relock
// - POR sets only the power-on flag
// - Loss in bus wait sets requester and loss flags
// - Plain synchronous sequence sets only requester flags
// - Internal sequence sets loss flags plus any soft/watchdog request of that cycle
// - Software bit cleared by its own reset
// - Cause flags read-only at any time
// - Force bit drives reset output directly
module rsc_reset_sequencer
    import rsc_pkg::*;
#(
    parameter int CFG_W = 8,
    parameter int RELEASE_N = RELEASE_CYCLES
) (
    input wire logic clk_i, // System clock, 20 MHz
    input wire logic rst_i, // Synchronous reset, high
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write
    input wire logic [31:0] adr_i, // Wishbone byte address
    input wire logic [3:0] sel_i, // Wishbone byte enables
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    input wire logic power_low_i, // Supply below minimum, high
    input wire logic reset_n_i, // External reset pin, low
    input wire logic pll_lock_i, // PLL lock indication
    input wire logic config_latch_select_n_i, // Config latch select pin, low
    input wire logic [CFG_W-1:0] config_data_i, // Config pins
    input wire logic stop_mode_i, // Low-power stop active
    input wire logic watchdog_i, // Watchdog timeout pulse
    input wire logic pll_ref_fail_i, // PLL reference failed
    input wire logic pll_fail_i, // PLL failed
    input wire logic bus_cycle_active_i, // Bus cycle in progress
    input wire logic bus_cycle_done_i, // Bus cycle terminated normally
    output logic bus_monitor_on_o, // Bus monitor enable
    output logic bus_terminate_o, // End current bus cycle
    output logic sys_reset_o, // Internal system reset
    output logic reset_out_pin_n_o, // Reset output pin, low
    output logic [CFG_W-1:0] config_latched_o // Latched configuration
);
    localparam int PW = CFG_W + 4;
    localparam int CNT_W = $clog2(RELEASE_N);
    localparam logic [PW-1:0] PIN_RST = {{CFG_W{1'b0}}, 4'hb};
    localparam logic [2:0] PIN_MAX = 3'(PIN_MIN_EDGES);

    function automatic logic [BM_CNT_W-1:0] bm_limit(input logic [BM_TO_W-1:0] field);
        bm_limit = BM_CNT_W'((int'(field) + 1) * BM_UNIT_CYCLES - 1);
    endfunction

    rsc_state_type state_reg, state_next;
    logic [PW-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg, pin_f_next;
    logic [2:0] pin_cnt_reg, pin_cnt_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [BM_CNT_W-1:0] bm_cnt_reg, bm_cnt_next;
    logic [7:0] cause_reg, cause_next, cfg_reg, cfg_next;
    logic [CFG_W-1:0] cfg_lat_reg, cfg_lat_next;
    logic [2:0] pend_reg, pend_next;
    logic soft_reg, soft_next, force_reg, force_next;
    logic seq_rst_reg, lock_d_reg, ack_reg;
    logic [31:0] dat_reg, rd_mux;

    // Filtered pins
    wire por_f = pin_f_reg[0];
    wire rstn_f = pin_f_reg[1];
    wire lock_f = pin_f_reg[2];
    wire cfg_sel_n_f = pin_f_reg[3];
    wire [CFG_W-1:0] cfg_pins_f = pin_f_reg[PW-1:4];

    wire pll_mode = cfg_reg[CFG_PLL_MODE];
    wire lock_ok = ~pll_mode | lock_f;
    wire pin_held = (pin_cnt_reg == PIN_MAX) & ~stop_mode_i;
    wire stop_pin = stop_mode_i & ~rstn_f;
    wire clk_loss = pll_mode & cfg_reg[CFG_CLK_LOSS_EN] & (pll_ref_fail_i | pll_fail_i);
    wire lock_loss = pll_mode & cfg_reg[CFG_LOCK_LOSS_EN] & lock_d_reg & ~lock_f;
    wire async_req = clk_loss | lock_loss | stop_pin;
    wire sync_req = pin_held | watchdog_i | soft_reg;
    wire deferring = state_reg == ST_SYNC_WAIT;
    wire bm_on = cfg_reg[CFG_BM_EN] | deferring;
    wire bm_expire = bm_on & bus_cycle_active_i & (bm_cnt_reg == bm_limit(cfg_reg[CFG_BM_TO_LSB +: BM_TO_W]));
    // Only a finished or timed-out cycle counts, so writes in flight complete
    wire bus_end = ~bus_cycle_active_i | bus_cycle_done_i | bm_expire;
    wire latch_sync = deferring & (state_next == ST_WAIT_PIN) & ~por_f;
    wire latch_async = (state_reg == ST_IDLE) & (state_next == ST_WAIT_LOCK | state_next == ST_WAIT_PIN) & ~por_f;

    // Wishbone decode
    wire wb_req = cyc_i & stb_i;
    wire wb_wr = wb_req & we_i & ack_reg;
    wire hit_ctrl = adr_i == OFS_CTRL_CAUSE;
    wire hit_cfg = adr_i == OFS_CONFIG;
    wire hit_stat = adr_i == OFS_STATUS;
    wire ctrl_wr = wb_wr & hit_ctrl & sel_i[CTRL_SEL];
    wire cfg_wr = wb_wr & hit_cfg & sel_i[CFG_SEL];
    // Shift instead of a zero-width filler when CFG_W reaches the flag position
    wire [31:0] stat_word = 32'(cfg_lat_reg) | (32'(seq_rst_reg) << STAT_ACTIVE_BIT);

    assign rd_mux = hit_ctrl ? ({soft_reg, force_reg, 6'h00, 24'h00_0000} | (32'(cause_reg) << CAUSE_LSB)) :
                    hit_cfg ? {24'h00_0000, cfg_reg} :
                    hit_stat ? stat_word : 32'h0000_0000;
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign bus_monitor_on_o = bm_on;
    assign bus_terminate_o = bm_expire | (deferring & async_req & ~por_f);
    assign sys_reset_o = seq_rst_reg;
    assign reset_out_pin_n_o = ~(seq_rst_reg | force_reg);
    assign config_latched_o = cfg_lat_reg;

    // A pin change counts once the two later stages agree
    assign pin_f_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
    assign pin_cnt_next = rstn_f ? 3'h0 : (pin_held ? pin_cnt_reg : pin_cnt_reg + 3'h1);
    // Counter restarts on any state other than the count itself
    assign cnt_next = (state_reg == ST_COUNT && state_next == ST_COUNT) ? cnt_reg + CNT_W'(1) : '0;
    assign bm_cnt_next = (bm_on & bus_cycle_active_i & ~bus_cycle_done_i & ~bm_expire) ? bm_cnt_reg + BM_CNT_W'(1) : '0;
    assign pend_next = (deferring ? pend_reg : 3'h0) | {soft_reg, watchdog_i, pin_held};
    // Write wins over the hardware clear so a fresh request is kept
    assign soft_next = ctrl_wr ? dat_i[CTRL_SOFT_BIT] : (soft_reg & ~latch_sync);
    assign force_next = ctrl_wr ? dat_i[CTRL_FORCE_BIT] : force_reg;
    assign cfg_next = cfg_wr ? dat_i[7:0] : cfg_reg;
    assign cfg_lat_next = (state_reg == ST_LATCH_CFG && !cfg_sel_n_f) ? cfg_pins_f : cfg_lat_reg;

    always_comb begin
        cause_next = cause_reg;
        if (state_next == ST_POR) begin
            cause_next = CAUSE_POR_ONLY;
        end else if (latch_sync) begin
            cause_next = '0;
            cause_next[CAUSE_SOFT] = pend_next[2];
            cause_next[CAUSE_WATCHDOG] = pend_next[1];
            cause_next[CAUSE_PIN] = pend_next[0];
            cause_next[CAUSE_CLK_LOSS] = clk_loss;
            cause_next[CAUSE_LOCK_LOSS] = lock_loss;
        end else if (latch_async) begin
            cause_next = '0;
            cause_next[CAUSE_SOFT] = soft_reg;
            cause_next[CAUSE_WATCHDOG] = watchdog_i;
            cause_next[CAUSE_PIN] = stop_pin;
            cause_next[CAUSE_CLK_LOSS] = clk_loss;
            cause_next[CAUSE_LOCK_LOSS] = lock_loss;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_POR: begin
                if (!por_f) begin
                    state_next = ST_WAIT_LOCK;
                end
            end
            ST_IDLE: begin
                if (stop_pin) begin
                    state_next = ST_WAIT_PIN;
                end else if (clk_loss | lock_loss) begin
                    state_next = ST_WAIT_LOCK;
                end else if (sync_req) begin
                    state_next = ST_SYNC_WAIT;
                end
            end
            ST_SYNC_WAIT: begin
                if (async_req | bus_end) begin
                    state_next = ST_WAIT_PIN;
                end
            end
            ST_WAIT_PIN: begin
                if (rstn_f) begin
                    state_next = ST_WAIT_LOCK;
                end
            end
            ST_WAIT_LOCK: begin
                if (pin_held) begin
                    state_next = ST_WAIT_PIN;
                end else if (lock_ok) begin
                    state_next = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (pin_held) begin
                    state_next = ST_WAIT_PIN;
                end else if (!lock_ok) begin
                    state_next = ST_WAIT_LOCK;
                end else if (cnt_reg == CNT_W'(RELEASE_N - 1)) begin
                    state_next = ST_LATCH_CFG;
                end
            end
            ST_LATCH_CFG: begin
                state_next = ST_IDLE;
            end
        endcase
        if (por_f) begin
            state_next = ST_POR;
        end
    end

    always_ff @(posedge clk_i) begin
        pin_s1_reg <= {config_data_i, config_latch_select_n_i, pll_lock_i, reset_n_i, power_low_i};
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        if (rst_i) begin
            pin_f_reg <= PIN_RST;
            pin_cnt_reg <= 3'h0;
            lock_d_reg <= 1'b0;
        end else begin
            pin_f_reg <= pin_f_next;
            pin_cnt_reg <= pin_cnt_next;
            lock_d_reg <= lock_f;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_POR;
            seq_rst_reg <= 1'b1;
            cnt_reg <= '0;
            bm_cnt_reg <= '0;
            pend_reg <= 3'h0;
            cause_reg <= CAUSE_POR_ONLY;
        end else begin
            state_reg <= state_next;
            // Asserted on the edge into any state other than idle or the bus wait
            seq_rst_reg <= state_next != ST_IDLE && state_next != ST_SYNC_WAIT;
            cnt_reg <= cnt_next;
            bm_cnt_reg <= bm_cnt_next;
            pend_reg <= pend_next;
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_reg <= 1'b0;
            force_reg <= 1'b0;
            cfg_reg <= CFG_RST;
            cfg_lat_reg <= '0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            soft_reg <= soft_next;
            force_reg <= force_next;
            cfg_reg <= cfg_next;
            cfg_lat_reg <= cfg_lat_next;
            ack_reg <= wb_req & ~ack_reg;
            dat_reg <= (wb_req & ~ack_reg & ~we_i) ? rd_mux : dat_reg;
        end
    end

    property p_defer_monitor;
        @(posedge clk_i) disable iff (rst_i) deferring |-> bus_monitor_on_o;
    endproperty
    a_defer_monitor: assert property (p_defer_monitor) else $error("monitor off while deferring");

    property p_sync_assert;
        @(posedge clk_i) disable iff (rst_i)
            deferring && bus_end && !por_f |=> sys_reset_o && state_reg == ST_WAIT_PIN;
    endproperty
    a_sync_assert: assert property (p_sync_assert) else $error("sync reset not asserted after bus end");

    property p_async_now;
        @(posedge clk_i) disable iff (rst_i)
            state_reg == ST_IDLE && (clk_loss || lock_loss) && !por_f |=> !reset_out_pin_n_o;
    endproperty
    a_async_now: assert property (p_async_now) else $error("async reset delayed");

    property p_no_loss_outside_pll;
        @(posedge clk_i) disable iff (rst_i)
            state_reg == ST_IDLE && !pll_mode && !sync_req && !stop_pin && !por_f |=> state_reg == ST_IDLE;
    endproperty
    a_no_loss_outside_pll: assert property (p_no_loss_outside_pll) else $error("loss reset outside PLL mode");

    property p_pin_back;
        @(posedge clk_i) disable iff (rst_i)
            (state_reg == ST_WAIT_LOCK || state_reg == ST_COUNT) && pin_held && !por_f |=> state_reg == ST_WAIT_PIN;
    endproperty
    a_pin_back: assert property (p_pin_back) else $error("pin reassert ignored");

    property p_lock_back;
        @(posedge clk_i) disable iff (rst_i)
            state_reg == ST_COUNT && !lock_ok && !pin_held && !por_f |=> state_reg == ST_WAIT_LOCK ##1 cnt_reg == '0;
    endproperty
    a_lock_back: assert property (p_lock_back) else $error("lock loss in count ignored");

    property p_por_restart;
        @(posedge clk_i) disable iff (rst_i) por_f |=> state_reg == ST_POR && cause_reg == CAUSE_POR_ONLY;
    endproperty
    a_por_restart: assert property (p_por_restart) else $error("power-on did not restart");

    property p_release_exact;
        @(posedge clk_i) disable iff (rst_i)
            $rose(state_reg == ST_LATCH_CFG) |-> $past(cnt_reg) == CNT_W'(RELEASE_N - 1) && sys_reset_o ##1 !sys_reset_o;
    endproperty
    a_release_exact: assert property (p_release_exact) else $error("release count wrong");

    property p_soft_clear;
        @(posedge clk_i) disable iff (rst_i) latch_sync && !ctrl_wr |=> !soft_reg;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("software request not cleared");

    property p_force;
        @(posedge clk_i) disable iff (rst_i) force_reg |-> !reset_out_pin_n_o;
    endproperty
    a_force: assert property (p_force) else $error("force bit did not drive pin");
endmodule // rsc_reset_sequencer

// >>> src/rsc_pkg.sv
// Constants, register map and state type of the reset sequence controller
package rsc_pkg;
    // Register word byte addresses
    localparam logic [31:0] OFS_CTRL_CAUSE = 32'h0000_0000;
    localparam logic [31:0] OFS_CONFIG = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0008;

    // Control byte in data bits 31:24, cause byte in 23:16
    localparam int CTRL_LSB = 24;
    localparam int CAUSE_LSB = 16;
    localparam int CTRL_SEL = 3;
    localparam int CTRL_SOFT_BIT = 31;
    localparam int CTRL_FORCE_BIT = 30;

    // Reset cause byte layout
    localparam int CAUSE_SOFT = 5;
    localparam int CAUSE_WATCHDOG = 4;
    localparam int CAUSE_POR = 3;
    localparam int CAUSE_PIN = 2;
    localparam int CAUSE_CLK_LOSS = 1;
    localparam int CAUSE_LOCK_LOSS = 0;
    localparam logic [7:0] CAUSE_POR_ONLY = 8'h08;

    // Configuration word, byte lane 0
    localparam int CFG_SEL = 0;
    localparam int CFG_PLL_MODE = 0;
    localparam int CFG_CLK_LOSS_EN = 1;
    localparam int CFG_LOCK_LOSS_EN = 2;
    localparam int CFG_BM_EN = 3;
    localparam int CFG_BM_TO_LSB = 4;
    localparam int BM_TO_W = 2;
    localparam logic [7:0] CFG_RST = 8'h00;

    // Status word: latched configuration in the low bits, then sequence flag
    localparam int STAT_ACTIVE_BIT = 8;

    // Timing
    localparam int RELEASE_CYCLES = 512;
    localparam int PIN_MIN_EDGES = 4;
    localparam int BM_UNIT_CYCLES = 64;
    localparam int BM_CNT_W = 10;

    typedef enum logic [2:0] {
        ST_POR,
        ST_IDLE,
        ST_SYNC_WAIT,
        ST_WAIT_PIN,
        ST_WAIT_LOCK,
        ST_COUNT,
        ST_LATCH_CFG
    } rsc_state_type;
endpackage

// >>> tb/rsc_board_model.sv
// Board side model: reset pin driver, bus cycle owner and PLL lock
module rsc_board_model (
    input wire logic clk_i, // System clock
    input wire logic hold_bus_i, // Keep a bus cycle open
    input wire logic pin_pulse_i, // Start a pin reset request
    input wire logic lock_i, // Wanted PLL lock level
    input wire logic bus_terminate_i, // Cycle cut by the controller
    output logic bus_cycle_active_o, // Bus cycle running
    output logic bus_cycle_done_o, // Normal end of cycle
    output logic reset_n_o, // Reset pin, low
    output logic pll_lock_o // PLL lock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] pin_cnt;
    initial begin
        pin_cnt = 4'h0;
        bus_cycle_active_o = 1'b0;
        bus_cycle_done_o = 1'b0;
        pll_lock_o = 1'b1;
    end
    // Pin held low eight edges, twice the minimum
    assign reset_n_o = (pin_cnt == 4'h0);
    always @(posedge clk_i) begin
        pin_cnt <= pin_pulse_i ? 4'h8 : (pin_cnt != 4'h0 ? pin_cnt - 4'h1 : 4'h0);
        bus_cycle_active_o <= hold_bus_i & ~bus_terminate_i;
        bus_cycle_done_o <= bus_cycle_active_o & ~hold_bus_i;
        pll_lock_o <= lock_i;
    end
endmodule // rsc_board_model

// >>> tb/rsc_reset_sequencer_bench.sv
// Self-checking bench for the reset sequence controller
module rsc_reset_sequencer_bench;
    import rsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RN = 16;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, rd;
    logic [3:0] sel = 4'h0;
    logic ack, power_low = 1'b1, stop = 1'b0, wdog = 1'b0, hold_bus = 1'b0, pin_pulse = 1'b0, lock = 1'b1;
    logic act, done, term, mon_on, sys_rst, pin_n, rst_n, pll_lock;
    logic [7:0] cfg_lat;
    int err_count = 0, compares = 0, hi_cnt;

    rsc_reset_sequencer #(.CFG_W(8), .RELEASE_N(RN)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .power_low_i(power_low), .reset_n_i(rst_n), .pll_lock_i(pll_lock), .config_latch_select_n_i(1'b0),
        .config_data_i(8'h5a), .stop_mode_i(stop), .watchdog_i(wdog), .pll_ref_fail_i(1'b0),
        .pll_fail_i(1'b0), .bus_cycle_active_i(act), .bus_cycle_done_i(done), .bus_monitor_on_o(mon_on),
        .bus_terminate_o(term), .sys_reset_o(sys_rst), .reset_out_pin_n_o(pin_n), .config_latched_o(cfg_lat));
    rsc_board_model board (.clk_i(clk_i), .hold_bus_i(hold_bus), .pin_pulse_i(pin_pulse), .lock_i(lock),
        .bus_terminate_i(term), .bus_cycle_active_o(act), .bus_cycle_done_o(done), .reset_n_o(rst_n),
        .pll_lock_o(pll_lock));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task print_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Stuck waits end the run instead of hanging it
    task give_up();
        err_count++;
        print_verdict();
    endtask

    task wb(input logic w, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20) give_up();
        // Let the write settle before callers look at its effect
        @(posedge clk_i);
    endtask

    task wait_hi(input int lim);
        int n;
        for (n = 0; n < lim && sys_rst !== 1'b1; n++) @(posedge clk_i);
        if (sys_rst !== 1'b1) give_up();
    endtask

    task wait_lo();
        for (hi_cnt = 0; hi_cnt < 3000 && sys_rst !== 1'b0; hi_cnt++) @(posedge clk_i);
        if (sys_rst !== 1'b0) give_up();
        repeat (2) @(posedge clk_i);
    endtask

    task cause(input logic [7:0] e);
        wb(1'b0, OFS_CTRL_CAUSE, 4'hf, 32'h0);
        chk({24'h0, rd[23:16]}, {24'h0, e});
    endtask

    task t_por();
        wait_lo();
        cause(CAUSE_POR_ONLY);
        chk(pin_n, 1'b1);
        wb(1'b0, OFS_CONFIG, 4'hf, 32'h0);
        chk(rd, {24'h0, CFG_RST});
        wb(1'b0, OFS_STATUS, 4'hf, 32'h0);
        chk(rd, 32'h5a);
        wb(1'b1, 32'h10, 4'hf, 32'hffff_ffff);
        wb(1'b0, 32'h10, 4'hf, 32'h0);
        chk(rd, 32'h0);
    endtask

    task t_soft();
        hold_bus <= 1'b1;
        wb(1'b1, OFS_CTRL_CAUSE, 4'h8, 32'h8000_0000);
        repeat (6) @(posedge clk_i);
        chk(sys_rst, 1'b0);
        chk(mon_on, 1'b1);
        hold_bus <= 1'b0;
        wait_hi(6);
        wait_lo();
        chk(hi_cnt >= RN + 1, 1'b1);
        cause(8'h20);
        chk(rd[31], 1'b0);
        chk(mon_on, 1'b0);
    endtask

    task t_force_wdog();
        wb(1'b1, OFS_CTRL_CAUSE, 4'hc, 32'h40ff_0000);
        chk(pin_n, 1'b0);
        chk(sys_rst, 1'b0);
        cause(8'h20);
        wb(1'b1, OFS_CTRL_CAUSE, 4'h8, 32'h0);
        chk(pin_n, 1'b1);
        wdog <= 1'b1;
        @(posedge clk_i);
        wdog <= 1'b0;
        wait_hi(6);
        wait_lo();
        cause(8'h10);
    endtask

    task t_pin();
        pin_pulse <= 1'b1;
        @(posedge clk_i);
        pin_pulse <= 1'b0;
        wait_hi(20);
        wait_lo();
        cause(8'h04);
        stop <= 1'b1;
        pin_pulse <= 1'b1;
        @(posedge clk_i);
        pin_pulse <= 1'b0;
        wait_hi(12);
        stop <= 1'b0;
        wait_lo();
        cause(8'h04);
    endtask

    task t_lock();
        wb(1'b1, OFS_CONFIG, 4'h1, 32'h01);
        lock <= 1'b0;
        repeat (12) @(posedge clk_i);
        chk(sys_rst, 1'b0);
        lock <= 1'b1;
        repeat (12) @(posedge clk_i);
        wb(1'b1, OFS_CONFIG, 4'h1, 32'h05);
        lock <= 1'b0;
        wait_hi(8);
        repeat (40) @(posedge clk_i);
        chk(sys_rst, 1'b1);
        lock <= 1'b1;
        wait_lo();
        cause(8'h01);
        hold_bus <= 1'b1;
        wb(1'b1, OFS_CTRL_CAUSE, 4'h8, 32'h8000_0000);
        repeat (3) @(posedge clk_i);
        lock <= 1'b0;
        wait_hi(12);
        hold_bus <= 1'b0;
        repeat (10) @(posedge clk_i);
        lock <= 1'b1;
        wait_lo();
        cause(8'h21);
    endtask

    task t_por_mid();
        wb(1'b1, OFS_CTRL_CAUSE, 4'h8, 32'h8000_0000);
        wait_hi(8);
        repeat (8) @(posedge clk_i);
        power_low <= 1'b1;
        repeat (5) @(posedge clk_i);
        power_low <= 1'b0;
        wait_lo();
        cause(CAUSE_POR_ONLY);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        power_low <= 1'b0;
        t_por();
        t_soft();
        t_force_wdog();
        t_pin();
        t_lock();
        t_por_mid();
        print_verdict();
    end
endmodule // rsc_reset_sequencer_bench
